/* e1ec_consts.svh */
// Register offsets, field positions, reset values and timing figures
// for the receive error counters; definitions only, included by name.
`ifndef E1EC_CONSTS_SVH
`define E1EC_CONSTS_SVH

// Byte addresses on the parallel control port
`define E1EC_ADDR_CRC_HIGH_FAS_HIGH 8'h02
`define E1EC_ADDR_CRC_LOW           8'h03
`define E1EC_ADDR_EBIT_HIGH_FAS_LOW 8'h04
`define E1EC_ADDR_EBIT_LOW          8'h05

// Counter widths and field positions
`define E1EC_CRC_W        10
`define E1EC_EBIT_W       10
`define E1EC_FAS_W        12
`define E1EC_FAS_FIELD_LO 2
`define E1EC_FAS_SPLIT    6

// Frames of the CRC4 multiframe whose first bit carries an E bit
`define E1EC_EBIT_FRAME_A 4'hD
`define E1EC_EBIT_FRAME_B 4'hF

// Reset and unmapped read values
`define E1EC_RESET_BYTE   8'h00
`define E1EC_UNMAPPED     8'h00

// Update intervals, in ns as printed, and the clock period in ns
`define E1EC_CLK_NS       8
`define E1EC_SLOW_NS      1000000000
`define E1EC_FAST_NS      62500000
`define E1EC_SLOW_CYCLES  (`E1EC_SLOW_NS / `E1EC_CLK_NS)
`define E1EC_FAST_CYCLES  (`E1EC_FAST_NS / `E1EC_CLK_NS)

`endif

/* e1ec_pkg.sv */
// Types shared by the receive error counter block.
// Assumes the constants header defines the field widths.
`include "e1ec_consts.svh"

package e1ec_pkg;

  // Receive framer indications, sampled every clock
  typedef struct packed {
    logic       frame_start;
    logic [3:0] frame_num;
    logic       first_bit;
    logic       crc_fail;
    logic       fas_err;
  } e1ec_rx_t;

  // Synchronisation state of the receive framer
  typedef struct packed {
    logic receive_sync_lost;
    logic crc4_sync_lost;
    logic cas_sync_lost;
  } e1ec_sync_t;

  // Parallel control port access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } e1ec_host_t;

endpackage

/* e1ec_counters.sv */
// Receive performance counters: CRC4 codeword, E-bit and alignment word
// errors, latched into byte registers at each update boundary.
// Assumes framer indications and host strobes are synchronous to clk.
`timescale 1ns/1ps
`include "e1ec_consts.svh"

// Contract
// - CRC4 count bits 9..8 sit in bits 1..0 at 0x02 and bits 7..0 at 0x03.
// - The top six alignment count bits sit in bits 7..2 at 0x02.
// - With CRC4 multiframing the E-bit counter looks at the first bit of frames 13 and 15.
// - The E-bit counter rises by one for each E bit of zero and not for a one.
// - The E-bit counter stops while alignment or CRC4 sync is lost, not for CAS loss alone.
// - The low six alignment count bits sit in bits 7..2 at 0x04.
// - The alignment counter is twelve bits and rises once per bad alignment word.
// - The alignment counter holds while receive sync is lost.
// - The E-bit counter is ten bits wide and needs no saturation.
// - The alignment counter holds 4000 errors a second without saturation.
// - Alignment count bit 0 is bit 2 at 0x04 and bit 11 is bit 7 at 0x02.
// - Counts transfer every second, or every 62.5 ms when fast update is selected.
// - The CRC4 counter stops while alignment or CRC4 sync is lost, not for CAS loss alone.
// - The CRC4 counter rises once per failed sub-multiframe codeword.
module e1ec_counters
  import e1ec_pkg::*;
#(
  parameter int SLOW_CYCLES = `E1EC_SLOW_CYCLES,
  parameter int FAST_CYCLES = `E1EC_FAST_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Framer side
  input  wire e1ec_rx_t   rx,
  input  wire e1ec_sync_t sync,
  input  wire logic       crc4_mode,
  input  wire logic       fast_update_select,
  // Parallel control port
  input  wire e1ec_host_t host,
  output logic [7:0]      rdata_r,
  output logic            rvalid_r,
  // Update boundary marker
  output logic            update_tick_r
);

  localparam int TW = 32;

  // The boundary compare needs at least two cycles per interval
  if (FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES) begin : g_bad_period
    $error("e1ec_counters: update periods out of range");
  end

  logic [TW-1:0]              timer_r;
  logic [TW-1:0]              period;
  logic                       tick;
  logic [`E1EC_CRC_W-1:0]     crc_acc_r;
  logic [`E1EC_EBIT_W-1:0]    ebit_acc_r;
  logic [`E1EC_FAS_W-1:0]     fas_acc_r;
  logic [`E1EC_CRC_W-1:0]     crc_hold_r;
  logic [`E1EC_EBIT_W-1:0]    ebit_hold_r;
  logic [`E1EC_FAS_W-1:0]     fas_hold_r;
  logic                       frame_lost;
  logic                       crc_inc;
  logic                       ebit_inc;
  logic                       fas_inc;
  logic [7:0]                 rd_nxt;

  // Interval timer; the period is picked afresh each cycle so a change of
  // the select takes effect within the running interval.
  assign period = fast_update_select ? TW'(FAST_CYCLES) : TW'(SLOW_CYCLES);
  assign tick   = (timer_r >= period - TW'(1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_r <= '0;
    end else if (tick) begin
      timer_r <= '0;
    end else begin
      timer_r <= timer_r + TW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      update_tick_r <= 1'b0;
    end else begin
      update_tick_r <= tick;
    end
  end

  // CAS multiframe loss is deliberately not a term here
  assign frame_lost = sync.receive_sync_lost | sync.crc4_sync_lost;
  assign crc_inc    = rx.crc_fail & ~frame_lost;
  assign ebit_inc   = rx.frame_start & crc4_mode & ~rx.first_bit & ~frame_lost
                    & (rx.frame_num == `E1EC_EBIT_FRAME_A
                       || rx.frame_num == `E1EC_EBIT_FRAME_B);
  assign fas_inc    = rx.fas_err & ~sync.receive_sync_lost;

  // Accumulators: an event in the boundary cycle starts the new interval
  // at one so it is never lost. Widths cover the worst case per interval,
  // so no saturation is needed.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc_acc_r <= '0;
    end else if (tick) begin
      crc_acc_r <= `E1EC_CRC_W'(crc_inc);
    end else if (crc_inc) begin
      crc_acc_r <= crc_acc_r + `E1EC_CRC_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ebit_acc_r <= '0;
    end else if (tick) begin
      ebit_acc_r <= `E1EC_EBIT_W'(ebit_inc);
    end else if (ebit_inc) begin
      ebit_acc_r <= ebit_acc_r + `E1EC_EBIT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fas_acc_r <= '0;
    end else if (tick) begin
      fas_acc_r <= `E1EC_FAS_W'(fas_inc);
    end else if (fas_inc) begin
      fas_acc_r <= fas_acc_r + `E1EC_FAS_W'(1);
    end
  end

  // Holding registers change only at a boundary; host writes never reach them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc_hold_r  <= '0;
      ebit_hold_r <= '0;
      fas_hold_r  <= '0;
    end else if (tick) begin
      crc_hold_r  <= crc_acc_r;
      ebit_hold_r <= ebit_acc_r;
      fas_hold_r  <= fas_acc_r;
    end
  end

  // Read mux; the alignment count straddles two bytes
  always_comb begin
    unique case (host.addr)
      `E1EC_ADDR_CRC_HIGH_FAS_HIGH: rd_nxt = {fas_hold_r[11:6], crc_hold_r[9:8]};
      `E1EC_ADDR_CRC_LOW:           rd_nxt = crc_hold_r[7:0];
      `E1EC_ADDR_EBIT_HIGH_FAS_LOW: rd_nxt = {fas_hold_r[5:0], ebit_hold_r[9:8]};
      `E1EC_ADDR_EBIT_LOW:          rd_nxt = ebit_hold_r[7:0];
      default:                      rd_nxt = `E1EC_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r  <= `E1EC_RESET_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host.rd;
      if (host.rd) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_crc_high_byte;
    host.rd && host.addr == `E1EC_ADDR_CRC_HIGH_FAS_HIGH
      |=> rvalid_r && rdata_r == {$past(fas_hold_r[11:6]), $past(crc_hold_r[9:8])};
  endproperty
  a_crc_high_byte: assert property (p_crc_high_byte) else $error("byte 0x02 wrong");

  property p_crc_low_byte;
    host.rd && host.addr == `E1EC_ADDR_CRC_LOW |=> rdata_r == $past(crc_hold_r[7:0]);
  endproperty
  a_crc_low_byte: assert property (p_crc_low_byte) else $error("byte 0x03 wrong");

  property p_ebit_high_byte;
    host.rd && host.addr == `E1EC_ADDR_EBIT_HIGH_FAS_LOW
      |=> rdata_r == {$past(fas_hold_r[5:0]), $past(ebit_hold_r[9:8])};
  endproperty
  a_ebit_high_byte: assert property (p_ebit_high_byte) else $error("byte 0x04 wrong");

  property p_ebit_low_byte;
    host.rd && host.addr == `E1EC_ADDR_EBIT_LOW |=> rdata_r == $past(ebit_hold_r[7:0]);
  endproperty
  a_ebit_low_byte: assert property (p_ebit_low_byte) else $error("byte 0x05 wrong");

  property p_ebit_count;
    !tick && rx.frame_start && crc4_mode && !frame_lost && rx.frame_num == `E1EC_EBIT_FRAME_A
      |=> ebit_acc_r == $past(ebit_acc_r) + `E1EC_EBIT_W'(!$past(rx.first_bit));
  endproperty
  a_ebit_count: assert property (p_ebit_count) else $error("E-bit count step wrong");

  property p_ebit_frame_gate;
    !tick && rx.frame_start && rx.frame_num != `E1EC_EBIT_FRAME_A
      && rx.frame_num != `E1EC_EBIT_FRAME_B |=> $stable(ebit_acc_r);
  endproperty
  a_ebit_frame_gate: assert property (p_ebit_frame_gate) else $error("E-bit counted in wrong frame");

  property p_ebit_lost;
    !tick && frame_lost |=> $stable(ebit_acc_r);
  endproperty
  a_ebit_lost: assert property (p_ebit_lost) else $error("E-bit counted without sync");

  property p_fas_hold;
    !tick && sync.receive_sync_lost |=> $stable(fas_acc_r);
  endproperty
  a_fas_hold: assert property (p_fas_hold) else $error("alignment counter ran without sync");

  property p_fas_count;
    !tick && rx.fas_err && !sync.receive_sync_lost |=> fas_acc_r == $past(fas_acc_r) + `E1EC_FAS_W'(1);
  endproperty
  a_fas_count: assert property (p_fas_count) else $error("alignment count missed");

  property p_crc_count;
    !tick && rx.crc_fail |=> crc_acc_r == $past(crc_acc_r) + `E1EC_CRC_W'(!$past(frame_lost));
  endproperty
  a_crc_count: assert property (p_crc_count) else $error("CRC4 count step wrong");

  property p_transfer;
    tick |=> crc_hold_r == $past(crc_acc_r) && fas_hold_r == $past(fas_acc_r)
      && ebit_hold_r == $past(ebit_acc_r) && crc_acc_r == `E1EC_CRC_W'($past(crc_inc))
      && update_tick_r ##1 !update_tick_r;
  endproperty
  a_transfer: assert property (p_transfer) else $error("boundary transfer wrong");

  property p_hold_stable;
    !tick |=> $stable(crc_hold_r) && $stable(ebit_hold_r) && $stable(fas_hold_r);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("holding register moved off boundary");

  property p_fast_period;
    tick && fast_update_select ##1 fast_update_select [*2] |-> timer_r == TW'(1);
  endproperty
  a_fast_period: assert property (p_fast_period) else $error("timer restart wrong");

  property p_timer_bound;
    timer_r < TW'(SLOW_CYCLES);
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("interval timer overran");

  property p_rvalid_follows;
    1'b1 |=> rvalid_r == $past(host.rd);
  endproperty
  a_rvalid_follows: assert property (p_rvalid_follows) else $error("read valid not one cycle after strobe");

  // A read in a quiet cycle must leave every accumulator alone
  property p_read_no_side;
    host.rd && !tick && !rx.crc_fail && !rx.fas_err && !rx.frame_start
      |=> $stable(crc_acc_r) && $stable(ebit_acc_r) && $stable(fas_acc_r);
  endproperty
  a_read_no_side: assert property (p_read_no_side) else $error("read disturbed a count");

  property p_write_ignored;
    host.wr && !host.rd && !tick
      |=> $stable(crc_hold_r) && $stable(ebit_hold_r) && $stable(fas_hold_r) && !rvalid_r && $stable(rdata_r);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("host write had an effect");

  property p_unmapped_read;
    host.rd && (host.addr < `E1EC_ADDR_CRC_HIGH_FAS_HIGH || host.addr > `E1EC_ADDR_EBIT_LOW)
      |=> rdata_r == `E1EC_UNMAPPED;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_crc_lost;
    !tick && frame_lost |=> $stable(crc_acc_r);
  endproperty
  a_crc_lost: assert property (p_crc_lost) else $error("CRC4 counted without sync");

  property p_crc_idle;
    !tick && !rx.crc_fail |=> $stable(crc_acc_r);
  endproperty
  a_crc_idle: assert property (p_crc_idle) else $error("CRC4 count moved without event");

  property p_fas_idle;
    !tick && !rx.fas_err |=> $stable(fas_acc_r);
  endproperty
  a_fas_idle: assert property (p_fas_idle) else $error("alignment count moved without event");

  property p_ebit_mode_gate;
    !tick && !crc4_mode |=> $stable(ebit_acc_r);
  endproperty
  a_ebit_mode_gate: assert property (p_ebit_mode_gate) else $error("E-bit counted without multiframing");

  // Loss of CAS multiframe alone must not stop the E-bit count
  property p_ebit_cas;
    !tick && rx.frame_start && crc4_mode && !rx.first_bit && rx.frame_num == `E1EC_EBIT_FRAME_B
      && !sync.receive_sync_lost && !sync.crc4_sync_lost && sync.cas_sync_lost
      |=> ebit_acc_r == $past(ebit_acc_r) + `E1EC_EBIT_W'(1);
  endproperty
  a_ebit_cas: assert property (p_ebit_cas) else $error("E-bit count stopped on CAS loss");

  c_ebit_counted: cover property (ebit_inc ##1 ebit_acc_r != '0);
  c_fast_tick:    cover property (fast_update_select && tick);
  c_tick_event:   cover property (tick && crc_inc);
  c_read_back:    cover property (host.rd && host.addr == `E1EC_ADDR_CRC_HIGH_FAS_HIGH ##1 rdata_r != '0);
  c_cas_only:     cover property (sync.cas_sync_lost && !frame_lost && crc_inc);

endmodule

/* e1ec_host_model.sv */
// Host processor model: single byte reads and writes on the parallel control port.
// Assumes one caller at a time, in the clk domain.
`timescale 1ns/1ps

module e1ec_host_model
  import e1ec_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Parallel control port
  output e1ec_host_t host
);
  initial host = '{rd: 1'b0, wr: 1'b0, addr: 8'hFF, wdata: 8'h00};

  // One strobe cycle per access; address and data flip afterwards so nothing stale is mistaken for a hold
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(posedge clk);
    host <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge clk);
    host <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the receive error counters: framer events, host reads through the model.
// Assumes shortened update periods; read results are checked from a queue by a monitor.
`timescale 1ns/1ps
`include "e1ec_consts.svh"

module testbench
  import e1ec_pkg::*;
;
  localparam int SLOW = 1000;
  localparam int FAST = 250;
  logic        clk;
  logic        reset;
  e1ec_rx_t    rx;
  e1ec_sync_t  sync;
  logic        crc4_mode;
  logic        fast_update_select;
  e1ec_host_t  host;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  logic        update_tick_r;
  int          failures;
  int          n_tests;
  int          seed;
  int          cnt;
  logic [7:0]  expq[$];
  logic [9:0]  crc_e;
  logic [9:0]  eb_e;
  logic [11:0] fas_e;

  e1ec_counters #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) e1ec_counters_i (
    .clk(clk), .reset(reset), .rx(rx), .sync(sync), .crc4_mode(crc4_mode),
    .fast_update_select(fast_update_select), .host(host), .rdata_r(rdata_r),
    .rvalid_r(rvalid_r), .update_tick_r(update_tick_r));
  e1ec_host_model e1ec_host_model_i (.clk(clk), .host(host));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("counts: %0d comparisons, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    expq.push_back(exp);
    e1ec_host_model_i.access(1'b0, addr, 8'h00);
  endtask

  task automatic read_all();
    rd(`E1EC_ADDR_CRC_HIGH_FAS_HIGH, {fas_e[11:6], crc_e[9:8]});
    rd(`E1EC_ADDR_CRC_LOW, crc_e[7:0]);
    rd(`E1EC_ADDR_EBIT_HIGH_FAS_LOW, {fas_e[5:0], eb_e[9:8]});
    rd(`E1EC_ADDR_EBIT_LOW, eb_e[7:0]);
    rd(8'h06, `E1EC_UNMAPPED);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (update_tick_r !== 1'b1 && n < 2 * SLOW);
  endtask

  // Dense intervals push every count past 8 bits so the split fields are exercised
  task automatic interval(input bit dense, input bit extra);
    e1ec_rx_t   r;
    e1ec_sync_t s;
    logic       m;
    int         n;
    crc_e = '0;
    eb_e = '0;
    fas_e = '0;
    for (int i = 0; i < SLOW - 60; i++) begin
      @(posedge clk);
      r = 8'($random(seed));
      s = 3'($random(seed));
      m = 1'($random(seed));
      if (dense) begin
        r = '{frame_start: 1'b1, frame_num: r.frame_num | 4'hD, first_bit: 1'b0, crc_fail: 1'b1, fas_err: 1'b1};
        s = '0;
        m = 1'b1;
      end
      rx <= r;
      sync <= s;
      crc4_mode <= m;
      crc_e += 10'(r.crc_fail & !s.receive_sync_lost & !s.crc4_sync_lost);
      fas_e += 12'(r.fas_err & !s.receive_sync_lost);
      eb_e += 10'(r.frame_start & m & !r.first_bit & !s.receive_sync_lost & !s.crc4_sync_lost
        & (r.frame_num == `E1EC_EBIT_FRAME_A || r.frame_num == `E1EC_EBIT_FRAME_B));
    end
    @(posedge clk);
    rx <= '0;
    wait_tick(n);
    chk("boundary reached", 12'h001, 12'(n < 2 * SLOW));
    read_all();
    if (extra) begin
      for (int a = 2; a < 6; a++)
        e1ec_host_model_i.access(1'b1, 8'(a), 8'($random(seed)));
      read_all();
    end
    $display("test interval dense=%0d done", dense);
  endtask

  task automatic gap(input logic f, input int exp);
    int n;
    fast_update_select <= f;
    wait_tick(n);
    chk("update spacing", 12'(exp), 12'(n));
  endtask

  always @(posedge clk) begin
    if (rvalid_r === 1'b1) begin
      if (expq.size() == 0)
        chk("unrequested read", 12'h000, 12'h001);
      else
        chk("read data", 12'(expq.pop_front()), 12'(rdata_r));
    end
  end

  initial begin
    seed = 53698;
    failures = 0;
    n_tests = 0;
    reset = 1'b1;
    rx = '0;
    sync = '0;
    crc4_mode = 1'b0;
    fast_update_select = 1'b0;
    crc_e = '0;
    eb_e = '0;
    fas_e = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    read_all();
    $display("test reset values done");
    wait_tick(cnt);
    interval(1'b1, 1'b0);
    interval(1'b0, 1'b1);
    interval(1'b0, 1'b0);
    wait_tick(cnt);
    gap(1'b1, FAST);
    gap(1'b1, FAST);
    gap(1'b0, SLOW);
    $display("test update spacing done");
    repeat (4) @(posedge clk);
    chk("pending reads", 12'h000, 12'(expq.size()));
    test_done();
  end

  initial begin
    repeat (12000) @(posedge clk);
    failures++;
    $display("unexpected timeout: expected finish, seen hang");
    test_done();
  end
endmodule
